// ---- ctc_trap.sv ----
// Overview of operation
// - Register form signed less-than traps when rs is below rt as signed values.
// - Immediate signed less-than traps when rs is below the sign-extended immediate.
// - Immediate unsigned less-than sign-extends the immediate then compares unsigned.
// - The unsigned immediate is never zero-extended, so only both range ends are reachable.
// - Register form unsigned less-than traps when rs is below rt as unsigned values.
// - Register form not-equal traps when rs and rt differ in any bit.
// - Immediate not-equal traps when rs differs from the sign-extended immediate.
// - The ten-bit code field of register forms is ignored by hardware.
// - These instructions raise no exception other than the trap.
`timescale 1ns/1ps
module ctc_trap (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // Instruction in the execute stage
  input  wire logic        instr_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] rs_val_i,
  input  wire logic [31:0] rt_val_i,
  // Exception stage
  output logic             trap_req_o,
  output logic             kill_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [5:0]        op;
  logic [4:0]        rt_sub;
  logic [5:0]        fn;
  logic [31:0]       imm_sx;
  logic              is_reg;
  logic              is_imm;
  ctc_pkg::ctc_cmp_e kind;
  logic [31:0]       rhs;
  logic              hit;
  logic              next_trap;

  assign op     = instr_i[ctc_pkg::OP_MSB:ctc_pkg::OP_LSB];
  assign rt_sub = instr_i[ctc_pkg::RT_MSB:ctc_pkg::RT_LSB];
  // Code field bits 15..6 never reach the decode
  assign fn     = instr_i[ctc_pkg::FN_MSB:ctc_pkg::FN_LSB];
  // Sign extension only, also for the unsigned form
  assign imm_sx = {{(ctc_pkg::DATA_W - ctc_pkg::IMM_W){instr_i[ctc_pkg::IMM_MSB]}},
                   instr_i[ctc_pkg::IMM_MSB:0]};
  assign is_reg = op == ctc_pkg::OP_REGISTER_OP_CLASS;
  assign is_imm = op == ctc_pkg::OP_REGISTER_IMMEDIATE_CLASS;

  function automatic ctc_pkg::ctc_cmp_e decode_kind(input logic       reg_f,
                                                    input logic       imm_f,
                                                    input logic [5:0] f,
                                                    input logic [4:0] s);
    if (reg_f && f == ctc_pkg::FN_TRAP_SIGNED_LESS) begin
      return ctc_pkg::CTC_CMP_SLT;
    end else if (reg_f && f == ctc_pkg::FN_TRAP_UNSIGNED_LESS) begin
      return ctc_pkg::CTC_CMP_ULT;
    end else if (reg_f && f == ctc_pkg::FN_TRAP_NOT_EQUAL) begin
      return ctc_pkg::CTC_CMP_NE;
    end else if (imm_f && s == ctc_pkg::RT_TRAP_SIGNED_LESS_IMM) begin
      return ctc_pkg::CTC_CMP_SLT;
    end else if (imm_f && s == ctc_pkg::RT_TRAP_UNSIGNED_LESS_IMM) begin
      return ctc_pkg::CTC_CMP_ULT;
    end else if (imm_f && s == ctc_pkg::RT_TRAP_NOT_EQUAL_IMM) begin
      return ctc_pkg::CTC_CMP_NE;
    end
    return ctc_pkg::CTC_CMP_NONE;
  endfunction

  assign kind = decode_kind(is_reg, is_imm, fn, rt_sub);
  assign rhs  = is_imm ? imm_sx : rt_val_i;

  ////////////////////////////////////////////////////////////////////////////
  // Compare
  ctc_compare u_cmp (
    .lhs_i  (rs_val_i),
    .rhs_i  (rhs),
    .kind_i (kind),
    .hit_o  (hit)
  );

  // A trap request and its paired kill are the only things that leave this block
  assign next_trap = instr_valid_i && hit;

  ////////////////////////////////////////////////////////////////////////////
  // Exception request register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trap_req_o <= 1'b0;
      kill_o     <= 1'b0;
    end else begin
      trap_req_o <= next_trap;
      kill_o     <= next_trap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Check helpers
  logic [31:0] imm_ref;

  assign imm_ref = {{16{instr_i[15]}}, instr_i[15:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the compare results
  chk_signed_less: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h32
    |=> trap_req_o == ($signed($past(rs_val_i)) < $signed($past(rt_val_i))))
    else $error("signed less trap wrong");

  chk_signed_sign: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h32
    && rs_val_i[31] && !rt_val_i[31] |=> trap_req_o)
    else $error("negative rs did not trap");

  chk_signed_imm: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h01 && instr_i[20:16] == 5'h0a
    |=> trap_req_o == ($signed($past(rs_val_i)) < $signed($past(imm_ref))))
    else $error("signed immediate trap wrong");

  chk_signed_imm_sign: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h01 && instr_i[20:16] == 5'h0a
    && rs_val_i[31] && !instr_i[15] |=> trap_req_o)
    else $error("negative rs did not trap on immediate");

  chk_unsigned_imm: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h01 && instr_i[20:16] == 5'h0b
    |=> trap_req_o == ($past(rs_val_i) < $past(imm_ref)))
    else $error("unsigned immediate trap wrong");

  chk_top_range: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h01 && instr_i[20:16] == 5'h0b
    && instr_i[15] && rs_val_i[31:16] == 16'h0000 |=> trap_req_o)
    else $error("unsigned immediate was zero-extended");

  chk_low_range: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h01 && instr_i[20:16] == 5'h0b
    && !instr_i[15] && rs_val_i >= 32'h00008000 |=> !trap_req_o)
    else $error("unsigned immediate low range wrong");

  chk_unsigned_less: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h33
    |=> trap_req_o == ($past(rs_val_i) < $past(rt_val_i)))
    else $error("unsigned less trap wrong");

  chk_unsigned_sign: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h33
    && rs_val_i[31] && !rt_val_i[31] |=> !trap_req_o)
    else $error("unsigned compare treated rs as signed");

  chk_not_equal: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h36
    |=> trap_req_o == ($past(rs_val_i) != $past(rt_val_i)))
    else $error("not equal trap wrong");

  chk_equal_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h36
    && rs_val_i == rt_val_i |=> !trap_req_o)
    else $error("equal operands trapped");

  chk_not_equal_imm: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h01 && instr_i[20:16] == 5'h0e
    |=> trap_req_o == ($past(rs_val_i) != $past(imm_ref)))
    else $error("not equal immediate trap wrong");

  chk_code_ignored: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h36
    && instr_i[15:6] != 10'h000 && rs_val_i != rt_val_i |=> trap_req_o)
    else $error("code field changed the result");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on what is refused
  chk_no_idle_trap: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !instr_valid_i |=> !trap_req_o)
    else $error("trap without instruction");

  chk_other_op_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_i[31:26] != 6'h00 && instr_i[31:26] != 6'h01 |=> !trap_req_o)
    else $error("trap from another opcode");

  chk_other_fn_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_i[31:26] == 6'h00 && !(instr_i[5:0] inside {6'h32, 6'h33, 6'h36})
    |=> !trap_req_o)
    else $error("trap from another function code");

  chk_other_sub_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_i[31:26] == 6'h01 && !(instr_i[20:16] inside {5'h0a, 5'h0b, 5'h0e})
    |=> !trap_req_o)
    else $error("trap from another subcode");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the request
  chk_kill_paired: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    trap_req_o == kill_o)
    else $error("kill and trap disagree");

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios reached
  cov_trap_reg: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && is_reg && hit ##1 trap_req_o);

  cov_trap_imm: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && is_imm && hit ##1 trap_req_o);

  cov_no_trap: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && kind != ctc_pkg::CTC_CMP_NONE && !hit);

  cov_back_to_back: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    trap_req_o ##1 trap_req_o);

  cov_code_field: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    instr_valid_i && is_reg && instr_i[15:6] != 10'h000 && hit ##1 trap_req_o);
endmodule // ctc_trap

// ---- ctc_pkg.sv ----
package ctc_pkg;
  // Instruction field positions
  localparam int OP_MSB   = 31;
  localparam int OP_LSB   = 26;
  localparam int RT_MSB   = 20;
  localparam int RT_LSB   = 16;
  localparam int FN_MSB   = 5;
  localparam int FN_LSB   = 0;
  localparam int IMM_MSB  = 15;
  localparam int IMM_W    = 16;
  localparam int DATA_W   = 32;
  // Opcode classes
  localparam logic [5:0] OP_REGISTER_OP_CLASS        = 6'h00;
  localparam logic [5:0] OP_REGISTER_IMMEDIATE_CLASS = 6'h01;
  // Function codes
  localparam logic [5:0] FN_TRAP_SIGNED_LESS   = 6'h32;
  localparam logic [5:0] FN_TRAP_UNSIGNED_LESS = 6'h33;
  localparam logic [5:0] FN_TRAP_NOT_EQUAL     = 6'h36;
  // Subcodes in the rt position
  localparam logic [4:0] RT_TRAP_SIGNED_LESS_IMM   = 5'h0a;
  localparam logic [4:0] RT_TRAP_UNSIGNED_LESS_IMM = 5'h0b;
  localparam logic [4:0] RT_TRAP_NOT_EQUAL_IMM     = 5'h0e;
  // Compare kinds
  typedef enum logic [1:0] {
    CTC_CMP_NONE = 2'b00,
    CTC_CMP_SLT  = 2'b01,
    CTC_CMP_ULT  = 2'b11,
    CTC_CMP_NE   = 2'b10
  } ctc_cmp_e;
endpackage

// ---- ctc_compare.sv ----
`timescale 1ns/1ps
module ctc_compare (
  // Operands
  input  wire logic [31:0]        lhs_i,
  input  wire logic [31:0]        rhs_i,
  // Selection
  input  wire ctc_pkg::ctc_cmp_e  kind_i,
  // Result
  output logic                    hit_o
);
  logic slt;
  logic ult;
  logic ne;
  assign slt = $signed(lhs_i) < $signed(rhs_i);
  assign ult = lhs_i < rhs_i;
  assign ne  = lhs_i != rhs_i;
  always_comb begin
    case (kind_i)
      ctc_pkg::CTC_CMP_SLT: hit_o = slt;
      ctc_pkg::CTC_CMP_ULT: hit_o = ult;
      ctc_pkg::CTC_CMP_NE:  hit_o = ne;
      default:              hit_o = 1'b0;
    endcase
  end
endmodule // ctc_compare

// ---- ctc_pipe_model.sv ----
`timescale 1ns/1ps
module ctc_pipe_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // Exception requests
  input  wire logic        trap_req_i,
  input  wire logic        kill_i,
  // Precise traps taken
  output logic      [15:0] taken_o
);
  // Takes a trap only when the instruction is also suppressed
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      taken_o <= 16'h0000;
    end else if (trap_req_i && kill_i) begin
      taken_o <= taken_o + 16'h0001;
    end
  end
endmodule // ctc_pipe_model

// ---- ctc_trap_test.sv ----
`timescale 1ns/1ps
module ctc_trap_test;
  logic        clk_sys_i     = 1'b0;
  logic        arst_n_i      = 1'b0;
  logic        instr_valid_i = 1'b0;
  logic [31:0] instr_i       = 32'h0;
  logic [31:0] rs_val_i      = 32'h0;
  logic [31:0] rt_val_i      = 32'h0;
  logic        trap_req_o;
  logic        kill_o;
  logic [15:0] taken;
  logic        note_q [$];
  logic        note;
  int          errors        = 0;
  int          comparisons   = 0;
  int          cycles        = 0;
  int          traps         = 0;
  int          seed          = 70;
  logic [5:0]  fn_tab [3]    = '{ctc_pkg::FN_TRAP_SIGNED_LESS, ctc_pkg::FN_TRAP_UNSIGNED_LESS,
                                 ctc_pkg::FN_TRAP_NOT_EQUAL};
  logic [4:0]  sub_tab [3]   = '{ctc_pkg::RT_TRAP_SIGNED_LESS_IMM,
                                 ctc_pkg::RT_TRAP_UNSIGNED_LESS_IMM, ctc_pkg::RT_TRAP_NOT_EQUAL_IMM};
  always #2.5 clk_sys_i = ~clk_sys_i;
  ctc_trap u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .rs_val_i(rs_val_i), .rt_val_i(rt_val_i), .trap_req_o(trap_req_o),
    .kill_o(kill_o));
  ctc_pipe_model u_pipe (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .trap_req_i(trap_req_o),
    .kill_i(kill_o), .taken_o(taken));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic expect_trap(logic v, logic [31:0] w, logic [31:0] a, logic [31:0] b);
    logic [31:0] imm;
    imm = {{16{w[15]}}, w[15:0]};
    if (v && w[31:26] == ctc_pkg::OP_REGISTER_OP_CLASS) begin
      if (w[5:0] == fn_tab[0]) return $signed(a) < $signed(b);
      if (w[5:0] == fn_tab[1]) return a < b;
      if (w[5:0] == fn_tab[2]) return a != b;
    end else if (v && w[31:26] == ctc_pkg::OP_REGISTER_IMMEDIATE_CLASS) begin
      if (w[20:16] == sub_tab[0]) return $signed(a) < $signed(imm);
      if (w[20:16] == sub_tab[1]) return a < imm;
      if (w[20:16] == sub_tab[2]) return a != imm;
    end
    return 1'b0;
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(logic v, logic [31:0] w, logic [31:0] a, logic [31:0] b);
    @(posedge clk_sys_i);
    instr_valid_i <= v;
    instr_i       <= w;
    rs_val_i      <= a;
    rt_val_i      <= b;
    note_q.push_back(expect_trap(v, w, a, b));
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_i) begin
    if (note_q.size() >= 2) begin
      note = note_q.pop_front();
      traps += int'(note);
      check("trap_req_o", trap_req_o, note);
      check("kill_o", kill_o, note);
    end
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] w;
    logic [31:0] a;
    int          k;
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    send(1'b1, 32'h00000032, 32'hffffffff, 32'h0);
    send(1'b1, 32'h0000fff2, 32'h80000000, 32'h1);
    send(1'b1, 32'h050b8000, 32'h00008000, 32'h0);
    send(1'b1, 32'h00000033, 32'hffffffff, 32'h0);
    send(1'b1, 32'h00000026, 32'h0, 32'h1);
    send(1'b0, 32'h00000032, 32'hffffffff, 32'h0);
    $display("test directed done");
    for (int i = 0; i < 600; i++) begin
      k = $unsigned($random(seed)) % 8;
      w = $random(seed);
      if (k < 3) {w[31:26], w[5:0]} = {ctc_pkg::OP_REGISTER_OP_CLASS, fn_tab[k]};
      else if (k < 6) {w[31:26], w[20:16]} = {ctc_pkg::OP_REGISTER_IMMEDIATE_CLASS, sub_tab[k-3]};
      a = $random(seed);
      a = (k >= 3 && k < 6) ? {{16{w[15]}}, w[15:0]} : a;
      a = a + 32'($random(seed) % 2);
      if ($random(seed) % 4 == 0) a = $random(seed);
      send(($random(seed) % 8) != 0, w, a, a - 32'($random(seed) % 2));
    end
    $display("test random done");
    send(1'b0, 32'h0, 32'h0, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    check("taken", {16'h0, taken}, 32'(traps));
    $display("test partner done");
    stop_test();
  end
endmodule // ctc_trap_test
